// ---- common/ppo_pkg.sv ----
// ****************************************
// shared constants
// ****************************************
package ppo_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int NCH = 3;
    localparam int NLANE = 6;
    localparam int SYNC_W = 7;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_SAMPLE = 12'hf26;
    localparam logic [11:0] IDX_OVERRIDE = 12'hf27;
    localparam logic [11:0] IDX_TRIG = 12'hf29;
    localparam logic [11:0] IDX_CTRL0 = 12'hf2c;

    // pin_level_sample fields
    localparam int SMP_FAULT_BIT = 6;
    // current_sense_trigger_ctrl fields
    localparam int TRG_POL_BIT = 7;
    localparam int TRG_HEN_BIT = 6;
    localparam int TRG_HIGH_INACTIVE_GROUP_EN_BIT = 5;
    localparam int TRG_LEN_BIT = 4;
    localparam int TRG_LOW_INACTIVE_GROUP_EN_BIT = 3;
    localparam int TRG_CH_LSB = 0;
    // modulator_control_0 fields
    localparam int CTL_OVREN_BIT = 0;
    localparam int CTL_OFF_LSB = 8;

    localparam logic [7:0] TRG_RST = 8'h00;
    localparam logic [5:0] OVR_RST = 6'h00;
    localparam logic [5:0] OFF_RST = 6'h00;
    localparam logic [6:0] SMP_RST = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_RST = 32'h0;

    // merges two channel triples: a[k] to bit 2k+1, b[k] to bit 2k
    function automatic logic [5:0] interleave(
        input logic [2:0] a,
        input logic [2:0] b
    );
        return {a[2], b[2], a[1], b[1], a[0], b[0]};
    endfunction : interleave

    function automatic logic reg_hit(
        input logic [13:0] addr,
        input logic [11:0] idx
    );
        return addr[13:2] == idx;
    endfunction : reg_hit
endpackage : ppo_pkg

// ---- tb/ppo_power_stage.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// power stage pins and current-sense adc
// ****************************************
module ppo_power_stage (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] highSideOut,
    input wire logic [2:0] lowSideOut,
    input wire logic conversionRequest,
    input wire logic faultLevel,
    output logic [2:0] highPinLevel,
    output logic [2:0] lowPinLevel,
    output logic fault0Pin,
    output logic [15:0] pulseCount,
    output logic [3:0] pulseWidth
);
    logic [3:0] run;

    // gate drivers always drive the pads, so pins echo the outputs
    assign highPinLevel = highSideOut;
    assign lowPinLevel = lowSideOut;
    assign fault0Pin = faultLevel;

    // adc counts starts and remembers the length of the last one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCount <= 16'h0;
            pulseWidth <= 4'h0;
            run <= 4'h0;
        end else if (conversionRequest) begin
            run <= run + 4'h1;
            if (run == 4'h0) begin
                pulseCount <= pulseCount + 16'h1;
            end
        end else begin
            if (run != 4'h0) begin
                pulseWidth <= run;
            end
            run <= 4'h0;
        end
    end
endmodule : ppo_power_stage
`default_nettype wire

// ---- tb/tb_ppo_pwm_override.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_ppo_pwm_override;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    int errCount = 0;
    int numChecks = 0;
    int cyc = 0;
    logic [13:0] awAddr = 14'h0;
    logic [13:0] arAddr = 14'h0;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'b0;
    logic wValid = 1'b0;
    logic bReady = 1'b0;
    logic arValid = 1'b0;
    logic rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, faultPin, convReq;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [2:0] modHigh = 3'h0;
    logic [2:0] modLow = 3'h0;
    logic faultActive = 1'b0;
    logic faultLevel = 1'b0;
    logic [2:0] hiOut, loOut, hiPin, loPin;
    logic [15:0] pulses;
    logic [3:0] width;
    localparam logic [1:0] OK = ppo_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ppo_pkg::RESP_SLVERR;
    // last entry masks every channel with only the low-active group on
    logic [7:0] cfg [9] = '{8'h47, 8'h41, 8'h27, 8'h17, 8'h0f, 8'hc7, 8'h07,
                            8'h47, 8'h10};
    logic [2:0] hA [9] = '{3'h6, 3'h0, 3'h1, 3'h0, 3'h7, 3'h7, 3'h0, 3'h7,
                           3'h5};
    logic [2:0] lA [9] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0,
                           3'h2};
    logic [2:0] hB [9] = '{3'h7, 3'h1, 3'h0, 3'h0, 3'h0, 3'h6, 3'h7, 3'h7,
                           3'h2};
    logic [2:0] lB [9] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0,
                           3'h5};

    always #5 clk = ~clk;

    ppo_pwm_override u_ppo_pwm_override (.clk(clk), .reset_n(reset_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .modHigh(modHigh),
        .modLow(modLow), .faultActive(faultActive), .highPinLevel(hiPin),
        .lowPinLevel(loPin), .fault0Pin(faultPin), .highSideOut(hiOut),
        .lowSideOut(loOut), .conversionRequest(convReq));

    ppo_power_stage u_ppo_power_stage (.clk(clk), .reset_n(reset_n),
        .highSideOut(hiOut), .lowSideOut(loOut), .conversionRequest(convReq),
        .faultLevel(faultLevel), .highPinLevel(hiPin), .lowPinLevel(loPin),
        .fault0Pin(faultPin), .pulseCount(pulses), .pulseWidth(width));

    task automatic results;
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic axiWrite(input logic [11:0] idx, input logic [31:0] d,
                            input logic [1:0] expResp);
        logic takeA, takeW;
        @(posedge clk);
        awAddr <= {idx, 2'h0};
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(negedge clk);
            takeA = awValid && awReady;
            takeW = wValid && wReady;
            @(posedge clk);
            if (takeA) awValid <= 1'b0;
            if (takeW) wValid <= 1'b0;
        end while ((awValid && !takeA) || (wValid && !takeW));
        do @(negedge clk); while (!bValid);
        check("bresp", {30'h0, expResp}, {30'h0, bResp});
        @(posedge clk);
        bReady <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [11:0] idx, input logic [31:0] exp,
                           input logic [1:0] expResp);
        logic take;
        @(posedge clk);
        arAddr <= {idx, 2'h0};
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(negedge clk);
            take = arReady;
            @(posedge clk);
        end while (!take);
        arValid <= 1'b0;
        do @(negedge clk); while (!rValid);
        check("rdata", exp, rData);
        check("rresp", {30'h0, expResp}, {30'h0, rResp});
        @(posedge clk);
        rReady <= 1'b0;
    endtask : axiRead

    task automatic setMod(input logic [2:0] h, input logic [2:0] l);
        @(posedge clk);
        modHigh <= h;
        modLow <= l;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : setMod

    task automatic checkOut(input logic [2:0] h, input logic [2:0] l);
        check("highSideOut", {29'h0, h}, {29'h0, hiOut});
        check("lowSideOut", {29'h0, l}, {29'h0, loOut});
    endtask : checkOut

    function automatic logic trigOf(input logic [7:0] c,
                                    input logic [2:0] h, input logic [2:0] l);
        logic [2:0] m;
        m = ~c[2:0];
        return c[7] ^ ((c[6] & (&(h | m))) | (c[4] & (&(l | m)))
                       | (c[5] & (&(~h | m))) | (c[3] & (&(~h | m))));
    endfunction : trigOf

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errCount++;
            results();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [2:0] oneHot;
        logic [15:0] p0, expP;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        check("ready", 32'h7, {29'h0, awReady, wReady, arReady});
        axiRead(ppo_pkg::IDX_SAMPLE, 32'h0, OK);
        axiRead(ppo_pkg::IDX_OVERRIDE, 32'h0, OK);
        axiRead(ppo_pkg::IDX_TRIG, 32'h0, OK);
        axiRead(12'hf2a, 32'h0, ERR);
        axiWrite(12'hf2a, 32'hff, ERR);
        // sample register is read only
        axiWrite(ppo_pkg::IDX_SAMPLE, 32'h7f, OK);
        axiRead(ppo_pkg::IDX_SAMPLE, 32'h0, OK);
        axiWrite(ppo_pkg::IDX_OVERRIDE, 32'hff, OK);
        axiRead(ppo_pkg::IDX_OVERRIDE, 32'h3f, OK);
        // override bits set but not enabled yet
        faultLevel <= 1'b1;
        setMod(3'h5, 3'h2);
        checkOut(3'h5, 3'h2);
        axiRead(ppo_pkg::IDX_SAMPLE, 32'h66, OK);
        faultLevel <= 1'b0;
        setMod(3'h2, 3'h5);
        axiRead(ppo_pkg::IDX_SAMPLE, 32'h19, OK);
        axiWrite(ppo_pkg::IDX_CTRL0, 32'h1, OK);
        setMod(3'h7, 3'h7);
        checkOut(3'h0, 3'h0);
        for (int k = 0; k < 6; k++) begin
            oneHot = 3'h1 << (k / 2);
            axiWrite(ppo_pkg::IDX_OVERRIDE, 32'h1 << k, OK);
            setMod(3'h7, 3'h7);
            checkOut((k % 2 == 0) ? ~oneHot : 3'h7,
                     (k % 2 == 1) ? ~oneHot : 3'h7);
        end
        // selected off level high on every lane
        axiWrite(ppo_pkg::IDX_CTRL0, 32'h3f01, OK);
        axiRead(ppo_pkg::IDX_CTRL0, 32'h3f01, OK);
        axiWrite(ppo_pkg::IDX_OVERRIDE, 32'h3f, OK);
        setMod(3'h0, 3'h0);
        checkOut(3'h7, 3'h7);
        axiWrite(ppo_pkg::IDX_OVERRIDE, 32'h0, OK);
        axiWrite(ppo_pkg::IDX_CTRL0, 32'h2a01, OK);
        faultActive <= 1'b1;
        setMod(3'h7, 3'h0);
        checkOut(3'h0, 3'h7);
        faultActive <= 1'b0;
        axiWrite(ppo_pkg::IDX_CTRL0, 32'h0, OK);
        for (int i = 0; i < 9; i++) begin
            axiWrite(ppo_pkg::IDX_TRIG, {24'h0, cfg[i]}, OK);
            setMod(hA[i], lA[i]);
            p0 = pulses;
            setMod(hB[i], lB[i]);
            expP = {15'h0, !trigOf(cfg[i], hA[i], lA[i])
                           && trigOf(cfg[i], hB[i], lB[i])};
            check("pulses", {16'h0, p0 + expP},
                  {16'h0, pulses});
            if (expP != 16'h0) check("width", 32'h1, {28'h0, width});
            checkOut(hB[i], lB[i]);
        end
        results();
    end
endmodule : tb_ppo_pwm_override
`default_nettype wire

// ---- verilog/ppo_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// three-stage pin synchroniser
// ****************************************
module ppo_pin_sync #(
    parameter int WIDTH = ppo_pkg::SYNC_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinLevel
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_pinLevel;

    // a change counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_pinLevel[i] = (stage2[i] == stage3[i]) ? stage3[i]
                                                         : pinLevel[i];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pinLevel <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            pinLevel <= next_pinLevel;
        end
    end
endmodule : ppo_pin_sync
`default_nettype wire

// ---- verilog/ppo_pwm_override.sv ----
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - sample reads six pwm pin levels
// - sample bit 6 shows fault0 pin
// - override bits act only with override_enable
// - overridden pin hides running modulator result
// - fault forces all outputs off state
// - odd override bits force low sides off
// - even override bits force high sides off
// - trigger is or of gated groups xor polarity
// - conversion starts only on trigger rise
// - bit 7 selects trigger polarity
// - bits 6..3 enable the four groups
// - masked channel terms evaluate as true
// - trigger settings never touch output pins
module ppo_pwm_override (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] modHigh,
    input wire logic [2:0] modLow,
    input wire logic faultActive,
    input wire logic [2:0] highPinLevel,
    input wire logic [2:0] lowPinLevel,
    input wire logic fault0Pin,
    output logic [2:0] highSideOut,
    output logic [2:0] lowSideOut,
    output logic conversionRequest
);
    // ****************************************
    // pin sampling
    // ****************************************
    logic [6:0] pinSample;

    ppo_pin_sync #(.WIDTH(ppo_pkg::SYNC_W)) u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn({fault0Pin, ppo_pkg::interleave(highPinLevel, lowPinLevel)}),
        .pinLevel(pinSample)
    );

    // ****************************************
    // register bus
    // ****************************************
    logic awHeld;
    logic wHeld;
    logic [13:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [5:0] overrideBits;
    logic [7:0] trigCtrl;
    logic overrideEnable;
    logic [5:0] offLevel;
    logic next_awHeld;
    logic next_wHeld;
    logic [13:0] next_awAddr;
    logic [31:0] next_wData;
    logic [3:0] next_wStrb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [5:0] next_overrideBits;
    logic [7:0] next_trigCtrl;
    logic next_overrideEnable;
    logic [5:0] next_offLevel;
    logic doWrite;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_overrideBits = overrideBits;
        next_trigCtrl = trigCtrl;
        next_overrideEnable = overrideEnable;
        next_offLevel = offLevel;
        doWrite = awHeld && wHeld && !s_axi_bvalid;
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ppo_pkg::RESP_OKAY;
            // sample register ignores writes
            if (ppo_pkg::reg_hit(awAddr, ppo_pkg::IDX_OVERRIDE)) begin
                if (wStrb[0]) begin
                    next_overrideBits = wData[5:0];
                end
            end else if (ppo_pkg::reg_hit(awAddr, ppo_pkg::IDX_TRIG)) begin
                if (wStrb[0]) begin
                    next_trigCtrl = wData[7:0];
                end
            end else if (ppo_pkg::reg_hit(awAddr, ppo_pkg::IDX_CTRL0)) begin
                if (wStrb[0]) begin
                    next_overrideEnable = wData[ppo_pkg::CTL_OVREN_BIT];
                end
                if (wStrb[1]) begin
                    next_offLevel = wData[ppo_pkg::CTL_OFF_LSB +: 6];
                end
            end else if (!ppo_pkg::reg_hit(awAddr, ppo_pkg::IDX_SAMPLE)) begin
                next_bresp = ppo_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_awHeld;
        next_wready = !next_wHeld;
    end

    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = ppo_pkg::RDATA_RST;
            next_rresp = ppo_pkg::RESP_OKAY;
            if (ppo_pkg::reg_hit(s_axi_araddr, ppo_pkg::IDX_SAMPLE)) begin
                next_rdata[6:0] = pinSample;
            end else if (ppo_pkg::reg_hit(s_axi_araddr,
                                          ppo_pkg::IDX_OVERRIDE)) begin
                next_rdata[5:0] = overrideBits;
            end else if (ppo_pkg::reg_hit(s_axi_araddr,
                                          ppo_pkg::IDX_TRIG)) begin
                next_rdata[7:0] = trigCtrl;
            end else if (ppo_pkg::reg_hit(s_axi_araddr,
                                          ppo_pkg::IDX_CTRL0)) begin
                next_rdata[ppo_pkg::CTL_OVREN_BIT] = overrideEnable;
                next_rdata[ppo_pkg::CTL_OFF_LSB +: 6] = offLevel;
            end else begin
                next_rresp = ppo_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= ppo_pkg::RDATA_RST;
            wStrb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ppo_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ppo_pkg::RDATA_RST;
            s_axi_rresp <= ppo_pkg::RESP_OKAY;
            overrideBits <= ppo_pkg::OVR_RST;
            trigCtrl <= ppo_pkg::TRG_RST;
            overrideEnable <= 1'b0;
            offLevel <= ppo_pkg::OFF_RST;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            overrideBits <= next_overrideBits;
            trigCtrl <= next_trigCtrl;
            overrideEnable <= next_overrideEnable;
            offLevel <= next_offLevel;
        end
    end

    // ****************************************
    // output override
    // ****************************************
    logic [5:0] modLane;
    logic [5:0] forceOff;
    logic [5:0] nextLane;
    logic [5:0] outLane;
    logic [2:0] next_highSideOut;
    logic [2:0] next_lowSideOut;
    // lane 2k is high side k, lane 2k+1 low side k
    always_comb begin
        modLane = ppo_pkg::interleave(modLow, modHigh);
        outLane = ppo_pkg::interleave(lowSideOut, highSideOut);
        if (faultActive) begin
            forceOff = '1;
        end else if (overrideEnable) begin
            forceOff = overrideBits;
        end else begin
            forceOff = '0;
        end
        // modulator keeps running, only its path is cut; trigger
        // settings have no path here
        nextLane = (forceOff & offLevel) | (~forceOff & modLane);
        for (int k = 0; k < ppo_pkg::NCH; k++) begin
            next_highSideOut[k] = nextLane[2*k];
            next_lowSideOut[k] = nextLane[2*k+1];
        end
    end

    // ****************************************
    // adc trigger
    // ****************************************
    logic [2:0] chanEn;
    logic [2:0] highTerm;
    logic [2:0] highNotTerm;
    logic [2:0] lowTerm;
    logic trigLevel;
    logic trigPrev;
    logic next_conversionRequest;
    always_comb begin
        chanEn = trigCtrl[ppo_pkg::TRG_CH_LSB +: 3];
        highTerm = highSideOut | ~chanEn;
        highNotTerm = ~highSideOut | ~chanEn;
        lowTerm = lowSideOut | ~chanEn;
        // fourth group uses inverted high sides as printed
        trigLevel = trigCtrl[ppo_pkg::TRG_POL_BIT] ^ (
            (trigCtrl[ppo_pkg::TRG_HEN_BIT] & (&highTerm)) |
            (trigCtrl[ppo_pkg::TRG_LEN_BIT] & (&lowTerm)) |
            (trigCtrl[ppo_pkg::TRG_HIGH_INACTIVE_GROUP_EN_BIT] & (&highNotTerm)) |
            (trigCtrl[ppo_pkg::TRG_LOW_INACTIVE_GROUP_EN_BIT] & (&highNotTerm)));
        next_conversionRequest = trigLevel && !trigPrev;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            highSideOut <= '0;
            lowSideOut <= '0;
            trigPrev <= 1'b0;
            conversionRequest <= 1'b0;
        end else begin
            highSideOut <= next_highSideOut;
            lowSideOut <= next_lowSideOut;
            trigPrev <= trigLevel;
            conversionRequest <= next_conversionRequest;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_fault_forces_off: assert property (
        faultActive |=> outLane == $past(offLevel)
    ) else $error("fault did not force off state");
    a_override_gated: assert property (
        !faultActive && !overrideEnable |=> outLane == $past(modLane)
    ) else $error("override acted while disabled");
    a_low_side_forced: assert property (
        !faultActive && overrideEnable && overrideBits[1]
        |=> lowSideOut[0] == $past(offLevel[1])
    ) else $error("low side 0 not forced off");
    a_high_side_forced: assert property (
        !faultActive && overrideEnable && overrideBits[4]
        |=> highSideOut[2] == $past(offLevel[4])
    ) else $error("high side 2 not forced off");
    a_free_lanes_pass: assert property (
        !faultActive && overrideEnable
        |=> (outLane & ~$past(overrideBits))
            == ($past(modLane) & ~$past(overrideBits))
    ) else $error("free lane lost modulator value");
    a_request_on_rise: assert property (
        !trigLevel ##1 trigLevel |=> conversionRequest
    ) else $error("trigger rise gave no request");
    a_request_single: assert property (
        conversionRequest |=> !conversionRequest
    ) else $error("request longer than one cycle");
    a_polarity_only: assert property (
        trigCtrl[6:3] == 4'h0 |-> trigLevel == trigCtrl[ppo_pkg::TRG_POL_BIT]
    ) else $error("trigger sense differs from polarity");
    a_masked_channels: assert property (
        chanEn == 3'h0 && trigCtrl[ppo_pkg::TRG_LEN_BIT]
        |-> trigLevel == !trigCtrl[ppo_pkg::TRG_POL_BIT]
    ) else $error("masked channels not true");
    a_low_inactive_grp: assert property (
        trigCtrl[6:3] == 4'h1 && chanEn == 3'h7
        |-> trigLevel == (trigCtrl[ppo_pkg::TRG_POL_BIT] ^ (&(~highSideOut)))
    ) else $error("fourth group mismatch");
    a_sample_read: assert property (
        s_axi_arvalid && s_axi_arready
        && ppo_pkg::reg_hit(s_axi_araddr, ppo_pkg::IDX_SAMPLE)
        |=> s_axi_rvalid && s_axi_rdata[5:0] == $past(pinSample[5:0])
    ) else $error("sample read wrong pin levels");
    a_sample_fault: assert property (
        s_axi_arvalid && s_axi_arready
        && ppo_pkg::reg_hit(s_axi_araddr, ppo_pkg::IDX_SAMPLE)
        |=> s_axi_rdata[ppo_pkg::SMP_FAULT_BIT] == $past(pinSample[6])
    ) else $error("sample read wrong fault level");
endmodule : ppo_pwm_override
`default_nettype wire
